// file: shared/pcseq_pkg.sv
// Constants and carrier types for the program counter sequencer.
// Assumes a 50 MHz system clock and APB register access.
package pcseq_pkg;

  // Widths
  localparam int PC_W    = 11;
  localparam int INSTR_W = 14;
  localparam int PCL_W   = 8;
  localparam int DADDR_W = 7;
  localparam int PADDR_W = 8;
  localparam int PHASES  = 4;

  // Fixed program addresses
  localparam logic [PC_W-1:0] VEC_RESET = 11'h000;
  localparam logic [PC_W-1:0] VEC_EXT   = 11'h004;
  localparam logic [PC_W-1:0] VEC_TMR   = 11'h008;
  localparam logic [PC_W-1:0] PC_ONE    = 11'h001;

  // Low program counter byte in data space
  localparam logic [DADDR_W-1:0] PCL_DADDR = 7'h06;

  // Register indices; byte address is four times the index
  localparam logic [PADDR_W-1:0] REG_CTRL_IDX = 8'h00;
  localparam logic [PADDR_W-1:0] REG_STAT_IDX = 8'h01;
  localparam logic [PADDR_W-1:0] REG_PCL_IDX  = 8'h06;
  localparam logic [PADDR_W-1:0] REG_CTRL_ADDR = {REG_CTRL_IDX[5:0], 2'b00};
  localparam logic [PADDR_W-1:0] REG_STAT_ADDR = {REG_STAT_IDX[5:0], 2'b00};
  localparam logic [PADDR_W-1:0] REG_PCL_ADDR  = {REG_PCL_IDX[5:0], 2'b00};

  // Control register fields and reset value
  localparam int CTRL_WAKE_BIT   = 0;
  localparam int CTRL_PINEN_BIT  = 1;
  localparam logic CTRL_PINEN_RST = 1'b1;

  // Status register fields
  localparam int STAT_PC_LSB    = 0;
  localparam int STAT_STATE_LSB = 11;
  localparam int STAT_VALID_BIT = 13;
  localparam int STAT_PHASE_LSB = 14;

  // Start-up wait after wake-up, in system clock periods
  localparam int SST_TSYS = 1024;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_WAKE
  } pcseq_state_t;

  // Execute-stage requests, valid at the last phase of a cycle
  typedef struct packed {
    logic jump;
    logic call;
    logic ret;
    logic skip;
    logic halt;
  } pcseq_ctl_t;

  // Return-address stack command
  typedef struct packed {
    logic            push;
    logic            pop;
    logic [PC_W-1:0] data;
  } pcseq_stk_t;

  // Core data-bus write into data space
  typedef struct packed {
    logic               we;
    logic [DADDR_W-1:0] addr;
    logic [PCL_W-1:0]   data;
  } pcseq_dwr_t;

endpackage

// file: rtl/pcseq_phase_gen.sv
// Four-phase generator for the instruction cycle.
// Assumes a synchronised active-low reset in the system clock domain.
`timescale 1ns/1ns
module pcseq_phase_gen
  import pcseq_pkg::*;
#(
  parameter int N = PHASES
)
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Phase outputs
  output logic [N-1:0]      phase_o,
  output logic              last_o
);

  logic [N-1:0] phase_q;

  // Rotating one-hot: phases never overlap
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_q <= {{(N-1){1'b0}}, 1'b1};
    end
    else
    begin
      phase_q <= {phase_q[N-2:0], phase_q[N-1]};
    end
  end

  assign phase_o = phase_q;
  assign last_o  = phase_q[N-1];

  property p_onehot;
    @(posedge clk_i) disable iff (!rst_n_i)
    $onehot(phase_q);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("phase clocks overlap or vanish");

  property p_cycle4;
    @(posedge clk_i) disable iff (!rst_n_i)
    phase_q[0] |=> phase_q[1] ##1 phase_q[2] ##1 phase_q[3] ##1 phase_q[0];
  endproperty
  a_cycle4: assert property (p_cycle4)
    else $error("instruction cycle is not four clocks");

endmodule

// file: rtl/pcseq_top.sv
// Program counter sequencer: phases, fetch/execute pipeline and PC.
// Assumes a program memory that returns the word at rom_addr_o within
// one cycle, an execute unit on the same clock, and an APB master.
//
// Overview of operation
// - System clock split into four phases
// - Instruction cycle lasts four clock periods
// - Fetch next while executing current instruction
// - PC advances by one after fetch
// - PC-changing instruction takes two cycles
// - Met skip discards prefetch, PC plus two
// - Write to low byte jumps within page
// - Jump or call loads instruction address
// - Return reloads PC from stack top
// - Wake-up waits 1024 clocks before execution
// - Reset clears PC to zero
// - Interrupts vector to 004H or 008H
// - Call or interrupt pushes PC first
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module pcseq_top
  import pcseq_pkg::*;
#(
  parameter int SST_CYCLES = SST_TSYS
)
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [PADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]         pwdata_i,
  input  wire logic [3:0]          pstrb_i,
  output logic                     pready_o,
  output logic [31:0]              prdata_o,
  output logic                     pslverr_o,
  // Program memory
  output logic [PC_W-1:0]          rom_addr_o,
  input  wire logic [INSTR_W-1:0]  rom_data_i,
  // Execute unit
  input  wire pcseq_ctl_t          ctl_i,
  input  wire pcseq_dwr_t          dwr_i,
  output logic [INSTR_W-1:0]       instr_o,
  output logic                     exec_valid_o,
  output logic [PHASES-1:0]        phase_o,
  // Return-address stack
  output pcseq_stk_t               stk_o,
  input  wire logic [PC_W-1:0]     stack_top_i,
  input  wire logic                stack_full_i,
  // Interrupts and wake-up
  input  wire logic                int_ext_req_i,
  input  wire logic                int_tmr_req_i,
  output logic [1:0]               int_ack_o,
  input  wire logic                wake_i,
  output logic                     halted_o
);

  localparam logic [10:0] SST_LAST = 11'(SST_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [1:0] wake_sync_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_sync_q <= 2'h0;
    end
    else
    begin
      wake_sync_q <= {wake_sync_q[0], wake_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase generator

  logic [PHASES-1:0] phase;
  logic              last;

  pcseq_phase_gen #(
    .N       (PHASES)
  ) u_phase (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .phase_o (phase),
    .last_o  (last)
  );

  assign phase_o = phase;

  ////////////////////////////////////////////////////////////////////////
  // State

  pcseq_state_t      st_q;
  logic [PC_W-1:0]   pc_q;
  logic [INSTR_W-1:0] instr_q;
  logic              valid_q;
  logic [10:0]       wake_cnt_q;
  logic              pcl_pend_q;
  logic [PCL_W-1:0]  pcl_val_q;
  logic              pin_en_q;
  logic              sw_wake_q;
  pcseq_stk_t        stk_q;
  logic [1:0]        ack_q;
  logic              halted_q;

  // Decisions at the cycle boundary
  logic run_b;
  logic do_ret;
  logic do_jmp;
  logic do_call;
  logic do_pcl;
  logic do_skip;
  logic do_halt;
  logic xfer;
  logic ack_ext;
  logic ack_tmr;
  logic plain;
  logic wake_ev;

  assign run_b   = last && (st_q == ST_RUN);
  assign do_ret  = run_b && valid_q && ctl_i.ret;
  assign do_jmp  = run_b && valid_q && !ctl_i.ret
                   && (ctl_i.jump || ctl_i.call);
  assign do_call = do_jmp && ctl_i.call;
  assign do_pcl  = run_b && !do_ret && !do_jmp && pcl_pend_q;
  assign do_skip = run_b && valid_q && ctl_i.skip
                   && !do_ret && !do_jmp && !do_pcl;
  assign do_halt = run_b && valid_q && ctl_i.halt
                   && !do_ret && !do_jmp && !do_pcl && !do_skip;
  assign xfer    = do_ret || do_jmp || do_pcl || do_skip || do_halt;
  // A full stack holds the request off until a return frees a level
  assign ack_ext = run_b && valid_q && !xfer && !stack_full_i
                   && int_ext_req_i;
  assign ack_tmr = run_b && valid_q && !xfer && !stack_full_i
                   && !int_ext_req_i && int_tmr_req_i;
  assign plain   = run_b && !xfer && !ack_ext && !ack_tmr;
  assign wake_ev = (pin_en_q && wake_sync_q[1]) || sw_wake_q;

  // Program counter
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q <= VEC_RESET;
    end
    else if (do_ret)
    begin
      pc_q <= stack_top_i;
    end
    else if (do_jmp)
    begin
      pc_q <= instr_q[PC_W-1:0];
    end
    else if (do_pcl)
    begin
      pc_q <= {pc_q[PC_W-1:PCL_W], pcl_val_q};
    end
    else if (ack_ext)
    begin
      pc_q <= VEC_EXT;
    end
    else if (ack_tmr)
    begin
      pc_q <= VEC_TMR;
    end
    else if (plain || do_skip)
    begin
      pc_q <= pc_q + PC_ONE;
    end
  end

  // Fetch register and its validity
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_q <= '0;
      valid_q <= 1'b0;
    end
    else if (last)
    begin
      instr_q <= rom_data_i;
      // Any change of flow turns the prefetched word into a dummy cycle
      valid_q <= plain;
    end
  end

  // Halt and start-up wait
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= ST_RUN;
      wake_cnt_q <= '0;
      halted_q   <= 1'b0;
    end
    else
    begin
      // Registered copy keeps the output straight from a flop
      halted_q <= (st_q != ST_RUN);
      unique case (st_q)
        ST_RUN:
        begin
          wake_cnt_q <= '0;
          if (do_halt)
          begin
            st_q <= ST_HALT;
          end
        end
        ST_HALT:
        begin
          if (wake_ev)
          begin
            st_q <= ST_WAKE;
          end
        end
        ST_WAKE:
        begin
          if (wake_cnt_q != SST_LAST)
          begin
            wake_cnt_q <= wake_cnt_q + 11'h001;
          end
          else if (last)
          begin
            st_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Stack commands and interrupt acknowledges, one clock each
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stk_q <= '0;
      ack_q <= 2'h0;
    end
    else
    begin
      stk_q.push <= do_call || ack_ext || ack_tmr;
      stk_q.pop  <= do_ret;
      stk_q.data <= pc_q;
      ack_q      <= {ack_tmr, ack_ext};
    end
  end

  assign rom_addr_o   = pc_q;
  assign instr_o      = instr_q;
  assign exec_valid_o = valid_q;
  assign stk_o        = stk_q;
  assign int_ack_o    = ack_q;
  assign halted_o     = halted_q;

  ////////////////////////////////////////////////////////////////////////
  // APB registers

  logic       pready_q;
  logic [31:0] prdata_q;
  logic       pslverr_q;
  logic       apb_wr;
  logic       hit;
  logic [31:0] rd_mux;
  logic       core_pcl_wr;
  logic       apb_pcl_wr;

  assign apb_wr = psel_i && penable_i && pwrite_i && pready_q;
  assign hit    = (paddr_i == REG_CTRL_ADDR) || (paddr_i == REG_STAT_ADDR)
                  || (paddr_i == REG_PCL_ADDR);
  assign core_pcl_wr = dwr_i.we && (dwr_i.addr == PCL_DADDR);
  assign apb_pcl_wr  = apb_wr && pstrb_i[0] && (paddr_i == REG_PCL_ADDR);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (paddr_i == REG_CTRL_ADDR)
    begin
      rd_mux[CTRL_PINEN_BIT] = pin_en_q;
    end
    else if (paddr_i == REG_STAT_ADDR)
    begin
      rd_mux[STAT_PC_LSB +: PC_W]      = pc_q;
      rd_mux[STAT_STATE_LSB +: 2]      = st_q;
      rd_mux[STAT_VALID_BIT]           = valid_q;
      rd_mux[STAT_PHASE_LSB +: PHASES] = phase;
    end
    else if (paddr_i == REG_PCL_ADDR)
    begin
      rd_mux[PCL_W-1:0] = pc_q[PCL_W-1:0];
    end
  end

  // One wait state; data and error stand with pready
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel_i && penable_i && !pready_q;
      prdata_q  <= (psel_i && !pwrite_i) ? rd_mux : 32'h0000_0000;
      pslverr_q <= psel_i && penable_i && !pready_q && !hit;
    end
  end

  // Control register; the wake command clears itself
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_en_q  <= CTRL_PINEN_RST;
      sw_wake_q <= 1'b0;
    end
    else if (apb_wr && pstrb_i[0] && (paddr_i == REG_CTRL_ADDR))
    begin
      pin_en_q  <= pwdata_i[CTRL_PINEN_BIT];
      sw_wake_q <= pwdata_i[CTRL_WAKE_BIT];
    end
    else
    begin
      sw_wake_q <= 1'b0;
    end
  end

  // Pending short jump; a new write in the applying clock wins
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcl_pend_q <= 1'b0;
      pcl_val_q  <= '0;
    end
    else if (core_pcl_wr)
    begin
      pcl_pend_q <= 1'b1;
      pcl_val_q  <= dwr_i.data;
    end
    else if (apb_pcl_wr)
    begin
      pcl_pend_q <= 1'b1;
      pcl_val_q  <= pwdata_i[PCL_W-1:0];
    end
    else if (do_pcl)
    begin
      pcl_pend_q <= 1'b0;
    end
  end

  assign pready_o  = pready_q;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_fetch;
    @(posedge ref_clk_i) disable iff (!rst_n)
    plain |=> valid_q && (instr_q == $past(rom_data_i));
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetched word not passed to execute");

  property p_inc;
    @(posedge ref_clk_i) disable iff (!rst_n)
    plain |=> pc_q == $past(pc_q) + PC_ONE;
  endproperty
  a_inc: assert property (p_inc)
    else $error("pc did not advance by one");

  property p_dummy;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (do_jmp || do_ret || do_pcl) |=> !valid_q [*4];
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("no dummy cycle after transfer");

  property p_skip;
    @(posedge ref_clk_i) disable iff (!rst_n)
    do_skip |=> !valid_q && (pc_q == $past(pc_q) + PC_ONE);
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip did not discard prefetch");

  property p_pcl;
    @(posedge ref_clk_i) disable iff (!rst_n)
    do_pcl |=> pc_q == {$past(pc_q[PC_W-1:PCL_W]), $past(pcl_val_q)};
  endproperty
  a_pcl: assert property (p_pcl)
    else $error("short jump left its page");

  property p_jump;
    @(posedge ref_clk_i) disable iff (!rst_n)
    do_jmp |=> pc_q == $past(instr_q[PC_W-1:0]);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not taken");

  property p_ret;
    @(posedge ref_clk_i) disable iff (!rst_n)
    do_ret |=> (pc_q == $past(stack_top_i)) && stk_q.pop;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not restore pc");

  property p_wake;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (st_q == ST_WAKE) ##1 (st_q == ST_RUN) |-> $past(wake_cnt_q) == SST_LAST;
  endproperty
  a_wake: assert property (p_wake)
    else $error("start-up wait cut short");

  property p_vec;
    @(posedge ref_clk_i) disable iff (!rst_n)
    ack_ext |=> (pc_q == VEC_EXT) && ack_q[0] && !valid_q;
  endproperty
  a_vec: assert property (p_vec)
    else $error("external interrupt vector wrong");

  property p_push;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (do_call || ack_tmr) |=> stk_q.push && (stk_q.data == $past(pc_q));
  endproperty
  a_push: assert property (p_push)
    else $error("return address not pushed");

endmodule

// file: test/pcseq_mem_model.sv
// Program memory and four-level return-address stack seen by the core.
// Assumes one-clock push and pop pulses on the system clock.
`timescale 1ns/1ns
module pcseq_mem_model
  import pcseq_pkg::*;
(
  // Clock
  input  wire logic               clk_i,
  // Program memory
  input  wire logic [PC_W-1:0]    addr_i,
  output logic [INSTR_W-1:0]      data_o,
  // Return-address stack
  input  wire pcseq_stk_t         stk_i,
  output logic [PC_W-1:0]         top_o,
  output logic                    full_o
);
  ////////////////////////////////////////////////////////////
  logic [PC_W-1:0] stk_q [4];
  int              cnt_q = 0;

  // Content differs from the address, so a stale fetch shows up
  function automatic logic [INSTR_W-1:0] word(logic [PC_W-1:0] a);
    return {3'h5, a ^ 11'h5a3};
  endfunction

  assign data_o = word(addr_i);
  // An empty stack shows no stale entry
  assign top_o  = (cnt_q == 0) ? ~stk_q[0] : stk_q[cnt_q-1];
  assign full_o = (cnt_q == 4);

  always @(posedge clk_i)
  begin
    if (stk_i.push && cnt_q < 4)
    begin
      stk_q[cnt_q] <= stk_i.data;
      cnt_q        <= cnt_q + 1;
    end
    else if (stk_i.pop && cnt_q > 0)
      cnt_q <= cnt_q - 1;
  end
endmodule

// file: test/program_counter_sequencer_tb.sv
// Self-checking bench for the program counter sequencer.
// Assumes the memory and stack model of pcseq_mem_model.
`timescale 1ns/1ns
module program_counter_sequencer_tb;
  import pcseq_pkg::*;
  localparam int SST = 8;
  logic               clk, nrst, psel, pen, pwr, pready, pslverr;
  logic               halted, ev, iext, itmr, wake, full;
  logic [7:0]         paddr, b;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb, phase;
  logic [1:0]         ack;
  logic [PC_W-1:0]    rom_addr, top, pc_e, sv;
  logic [INSTR_W-1:0] rom_data, instr, ex_w;
  pcseq_ctl_t         ctl;
  pcseq_dwr_t         dwr;
  pcseq_stk_t         stk;
  logic [25:0]        qp[$];
  logic [14:0]        qs[$];
  logic [33:0]        qa[$];
  logic [25:0]        nt;
  logic [14:0]        ns;
  logic [33:0]        ea;
  int                 err_total, n_checks, i, k;
  int                 nb = 0;
  int                 nb_s;

  pcseq_top #(.SST_CYCLES(SST)) pcseq_top_i (
    .ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .rom_addr_o(rom_addr), .rom_data_i(rom_data), .ctl_i(ctl),
    .dwr_i(dwr), .instr_o(instr), .exec_valid_o(ev), .phase_o(phase),
    .stk_o(stk), .stack_top_i(top), .stack_full_i(full),
    .int_ext_req_i(iext), .int_tmr_req_i(itmr), .int_ack_o(ack),
    .wake_i(wake), .halted_o(halted));
  pcseq_mem_model pcseq_mem_model_i (.clk_i(clk), .addr_i(rom_addr),
    .data_o(rom_data), .stk_i(stk), .top_o(top), .full_o(full));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Drives ctl_i into the cycle that ends at the next boundary
  task automatic step(input logic [4:0] c, input logic [PC_W-1:0] na,
                      input logic nv);
    int j = 0;
    @(posedge clk);
    while (phase !== 4'h4 && j < 8)
    begin
      @(posedge clk);
      j++;
    end
    if (j == 8)
    begin
      chk(1'b0, "no cycle boundary");
      print_verdict();
    end
    ctl <= c;
    @(posedge clk);
    ctl <= '0;
    qp.push_back({na, nv, pcseq_mem_model_i.word(pc_e)});
    ex_w = pcseq_mem_model_i.word(pc_e);
    pc_e = na;
    // The boundary just taken is counted by the watcher after this edge
    nb_s = nb + 1;
  endtask

  // Catches pc_e up with the boundaries that ran free since the last step
  task automatic resync();
    int j;
    for (j = 0; j < 8; j++)
    begin
      @(posedge clk);
      if (phase === 4'h2)
        break;
    end
    chk(j < 8, "phase lost");
    pc_e = pc_e + 11'(nb - nb_s);
    nb_s = nb;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    int j;
    qa.push_back(e);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (j = 0; j < 16; j++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    psel <= 1'b0;
    pen  <= 1'b0;
    if (j == 16)
    begin
      chk(1'b0, "bus answer missing");
      print_verdict();
    end
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    pc_e = VEC_RESET;
    nb_s = nb;
  endtask

  ////////////////////////////////////////////////////////////
  // Result watcher: takes the oldest note as each result shows
  always @(posedge clk)
  begin
    if (phase === 4'h8)
      nb <= nb + 1;
    if (phase === 4'h2 && qp.size() > 0)
    begin
      nt = qp.pop_front();
      chk(rom_addr === nt[25:15] && ev === nt[14], "fetch address");
      if (nt[14])
        chk(instr === nt[13:0], "executed word");
    end
    if ((stk.push | stk.pop | ack[0] | ack[1]) === 1'b1)
    begin
      ns = (qs.size() > 0) ? qs.pop_front() : 15'h7fff;
      chk({stk.push, stk.pop, ack} === {ns[14:13], ns[1:0]}, "stack op");
      if (ns[14])
        chk(stk.data === ns[12:2], "pushed address");
    end
    if ((pready & psel & pen) === 1'b1)
    begin
      ea = (qa.size() > 0) ? qa.pop_front() : '1;
      chk(pslverr === ea[32], "bus error flag");
      if (ea[33])
        chk(prdata === ea[31:0], "read data");
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    {psel, pen, pwr, iext, itmr, wake} = '0;
    {paddr, pwdata, ctl, dwr} = '0;
    pstrb = 4'h1;
    {err_total, n_checks} = '0;
    nrst = 1'b0;
    i = $urandom(32'hf3475666);
    do_reset();
    chk(rom_addr === VEC_RESET, "start address");
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      b[3:0] = phase;
      @(posedge clk);
      chk(phase === {b[2:0], b[3]}, "phase rotation");
    end
    resync();
    for (k = 0; k < 3 + $urandom % 4; k++)
      step(5'h00, pc_e + 1, 1'b1);
    $display("Test sequential done");
    step(5'h10, ex_w[10:0], 1'b0);
    step(5'h00, pc_e + 1, 1'b1);
    step(5'h02, pc_e + 1, 1'b0);
    step(5'h00, pc_e + 1, 1'b1);
    $display("Test jump and skip done");
    qs.push_back({2'b10, pc_e, 2'b00});
    sv = pc_e;
    step(5'h08, ex_w[10:0], 1'b0);
    step(5'h00, pc_e + 1, 1'b1);
    qs.push_back({2'b01, 11'h000, 2'b00});
    step(5'h04, sv, 1'b0);
    step(5'h00, pc_e + 1, 1'b1);
    $display("Test call and return done");
    for (k = 0; k < 2; k++)
    begin
      qs.push_back({2'b10, pc_e, k[0], ~k[0]});
      sv = pc_e;
      iext <= ~k[0];
      itmr <= k[0];
      step(5'h00, k[0] ? VEC_TMR : VEC_EXT, 1'b0);
      iext <= 1'b0;
      itmr <= 1'b0;
      step(5'h00, pc_e + 1, 1'b1);
      qs.push_back({2'b01, 11'h000, 2'b00});
      step(5'h04, sv, 1'b0);
      step(5'h00, pc_e + 1, 1'b1);
    end
    $display("Test interrupts done");
    b = $urandom;
    // Keeps the later increments inside the page
    b[7] = 1'b0;
    dwr <= '{1'b1, PCL_DADDR, b};
    @(posedge clk);
    dwr <= '0;
    step(5'h00, {pc_e[10:8], b}, 1'b0);
    step(5'h00, pc_e + 1, 1'b1);
    b = $urandom;
    apb(1'b1, REG_PCL_ADDR, {24'h0, b}, {2'b00, 32'h0});
    for (k = 0; k < 16 && rom_addr !== {pc_e[10:8], b}; k++)
      @(posedge clk);
    chk(k < 16, "short jump by register write");
    pc_e = {pc_e[10:8], b};
    nb_s = nb;
    step(5'h00, pc_e + 1, 1'b1);
    apb(1'b0, 8'h20, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 8'h24, 32'h1, {2'b01, 32'h0});
    apb(1'b0, REG_CTRL_ADDR, 32'h0, {2'b10, 32'h2});
    $display("Test registers done");
    resync();
    step(5'h01, pc_e, 1'b0);
    repeat (4) @(posedge clk);
    chk(halted === 1'b1 && rom_addr === pc_e, "halt entry");
    apb(1'b0, REG_PCL_ADDR, 32'h0, {2'b10, 24'h0, pc_e[7:0]});
    apb(1'b1, REG_CTRL_ADDR, 32'h3, {2'b00, 32'h0});
    for (k = 0; k < 64 && halted === 1'b1; k++)
      @(posedge clk);
    chk(k >= SST && k <= SST + 8, "start-up wait");
    $display("Test halt and wake done");
    repeat (9) @(posedge clk);
    do_reset();
    chk(rom_addr === VEC_RESET, "address after reset");
    step(5'h00, pc_e + 1, 1'b1);
    repeat (8) @(posedge clk);
    $display("Test second reset done");
    print_verdict();
  end
endmodule
